// File: bench/mvta_host_model.sv
// Host processor model: APB master for the register bank
module mvta_host_model (
  // Clock
  input  wire logic        ref_clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  int tmo_cnt = 0;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  // Entered just after a rising edge; hold keeps psel up so the next
  // setup cycle follows at once, needed to hit a busy table operation
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic hold,
                      output logic [31:0] q, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) tmo_cnt++;
    q   = prdata;
    err = pslverr;
    if (!hold) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask : xfer
endmodule : mvta_host_model

// File: bench/mvta_table_access_tb.sv
// Self-checking bench for the multicast and VLAN table access block
module mvta_table_access_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, vl_lk_vid;
  logic [31:0] pwdata, prdata, rq;
  logic        vlan_mode_en, vl_lk_req, mc_lk_req, re;
  logic [5:0]  mc_lk_addr_lsb;
  logic        vl_rv, vl_hit, vl_use, mc_rv;
  logic [2:0]  vl_pri, vl_spn;
  logic [6:0]  vl_fg, vl_str, vl_mem, mc_map;
  logic [15:0] lfsr = 16'h63e8;
  logic [11:0] vid [6];
  logic [31:0] e0 [6], e1 [6], e2 [6];
  logic [11:0] ra [7];
  int          grp [8];
  int          x;
  int          error_cnt = 0;
  int          checks_done = 0;

  mvta_table_access dut_u (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vlan_mode_en(vlan_mode_en),
    .vl_lk_req(vl_lk_req), .vl_lk_vid(vl_lk_vid), .vl_lk_rsp_vld(vl_rv),
    .vl_lk_hit(vl_hit), .vl_lk_use_member(vl_use),
    .vl_lk_priority(vl_pri), .vl_lk_spanning(vl_spn),
    .vl_lk_filter_group_id(vl_fg), .vl_lk_strip_map(vl_str),
    .vl_lk_member_map(vl_mem), .mc_lk_req(mc_lk_req),
    .mc_lk_addr_lsb(mc_lk_addr_lsb), .mc_lk_rsp_vld(mc_rv),
    .mc_lk_fwd_map(mc_map));

  mvta_host_model host_u (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rw(input logic w, input logic [11:0] a,
                    input logic [31:0] d, input logic h);
    host_u.xfer(w, a, d, h, rq, re);
    if (host_u.tmo_cnt != 0) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : rw

  // Polls a done flag; a flag stuck high ends the run
  task automatic poll(input logic [11:0] a, input int b);
    int n;
    n = 0;
    do begin
      rw(1'b0, a, 32'h0, 1'b0);
      n++;
    end while (rq[b] !== 1'b0 && n < 20);
    chk("done flag", {31'h0, rq[b]}, 32'h0);
    if (rq[b] !== 1'b0) tally_and_finish();
  endtask : poll

  task automatic mc_look(input logic [5:0] a, input logic [6:0] m);
    mc_lk_addr_lsb <= a;
    mc_lk_req      <= 1'b1;
    @(posedge ref_clk);
    mc_lk_req <= 1'b0;
    #1;
    chk("mc lookup", {24'h0, mc_rv, mc_map}, {24'h0, 1'b1, m});
    @(posedge ref_clk);
  endtask : mc_look

  task automatic vl_look(input int i, input logic en);
    vl_lk_vid <= vid[i];
    vl_lk_req <= 1'b1;
    @(posedge ref_clk);
    vl_lk_req <= 1'b0;
    #1;
    if (!en) chk("vlan off", {31'h0, vl_rv}, 32'h0);
    else chk("vlan lookup", {2'h0, vl_rv, vl_hit, vl_use, vl_pri, vl_spn,
             vl_fg, vl_str, vl_mem}, {2'h0, 1'b1, e0[i][31], e0[i][27],
             e0[i][26:24], e0[i][18:16], e0[i][6:0], e1[i][6:0],
             e2[i][6:0]});
    @(posedge ref_clk);
  endtask : vl_look

  initial begin
    #500us;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    srst           = 1'b1;
    vlan_mode_en   = 1'b0;
    vl_lk_req      = 1'b0;
    vl_lk_vid      = 12'h000;
    mc_lk_req      = 1'b0;
    mc_lk_addr_lsb = 6'h00;
    ra = '{mvta_pkg::ADDR_VL_E0, mvta_pkg::ADDR_VL_E1, mvta_pkg::ADDR_VL_E2,
           mvta_pkg::ADDR_VL_IDX, mvta_pkg::ADDR_VL_ACC,
           mvta_pkg::ADDR_RMC_CTRL, mvta_pkg::ADDR_RMC_DATA};
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (ra[i]) begin
      rw(1'b0, ra[i], 32'h0, 1'b0);
      chk("reset value", rq, 32'h0);
    end
    // Bits 29:7 read only, 31:30 kept
    rw(1'b1, mvta_pkg::ADDR_RMC_DATA, 32'hffffffff, 1'b0);
    rw(1'b0, mvta_pkg::ADDR_RMC_DATA, 32'h0, 1'b0);
    chk("mc data", rq, 32'hc000007f);
    $display("Test reset and data field done");
    for (int g = 0; g < 8; g++) begin
      grp[g] = int'(rnd() & 16'h007f);
      rw(1'b1, mvta_pkg::ADDR_RMC_DATA, 32'(grp[g]), 1'b0);
      x = g + 8 * int'(rnd() % 6);
      rw(1'b1, mvta_pkg::ADDR_RMC_CTRL, 32'h500 | 32'(x), 1'b0);
      poll(mvta_pkg::ADDR_RMC_CTRL, 10);
    end
    for (int g = 0; g < 8; g++) begin
      x = g + 8 * int'(rnd() % 6);
      rw(1'b1, mvta_pkg::ADDR_RMC_CTRL, 32'h700 | 32'(x), 1'b1);
      rw(1'b0, mvta_pkg::ADDR_RMC_CTRL, 32'h0, 1'b0);
      // Op finishes before a back-to-back read can sample it
      chk("mc ctrl", rq, 32'h300 | 32'(x));
      poll(mvta_pkg::ADDR_RMC_CTRL, 10);
      rw(1'b0, mvta_pkg::ADDR_RMC_DATA, 32'h0, 1'b0);
      chk("mc read", rq & 32'h7f, 32'(grp[g]));
      mc_look(6'(g + 8 * int'(rnd() % 6)), 7'(grp[g]));
    end
    mc_look(6'd50, 7'h00);
    $display("Test multicast table done");
    for (int i = 0; i < 6; i++) begin
      vid[i] = (i == 0) ? 12'h000 : (i == 5) ? 12'hfff :
               12'(i * 700 + int'(rnd() % 600));
      e0[i] = ({rnd(), rnd()} & 32'h0f07007f) | {i[0], 31'h0};
      e1[i] = 32'(rnd() & 16'h007f);
      e2[i] = 32'(rnd() & 16'h007f);
      rw(1'b1, mvta_pkg::ADDR_VL_E0, e0[i], 1'b0);
      rw(1'b1, mvta_pkg::ADDR_VL_E1, e1[i], 1'b0);
      rw(1'b1, mvta_pkg::ADDR_VL_E2, e2[i], 1'b0);
      rw(1'b1, mvta_pkg::ADDR_VL_IDX, {20'h0, vid[i]}, 1'b0);
      rw(1'b1, mvta_pkg::ADDR_VL_ACC, 32'h80, 1'b0);
      poll(mvta_pkg::ADDR_VL_ACC, 7);
    end
    for (int i = 0; i < 6; i++) begin
      rw(1'b1, mvta_pkg::ADDR_VL_E0, 32'h0, 1'b0);
      rw(1'b1, mvta_pkg::ADDR_VL_IDX, {20'h0, vid[i]}, 1'b0);
      rw(1'b1, mvta_pkg::ADDR_VL_ACC, 32'h81, 1'b1);
      // Lands while the read is busy: start reads one, a write is dropped
      if (i[0]) begin
        rw(1'b0, mvta_pkg::ADDR_VL_ACC, 32'h0, 1'b0);
        chk("start busy", {31'h0, rq[7]}, 32'h1);
      end else begin
        rw(1'b1, mvta_pkg::ADDR_VL_IDX, {20'h0, ~vid[i]}, 1'b0);
      end
      poll(mvta_pkg::ADDR_VL_ACC, 7);
      rw(1'b0, mvta_pkg::ADDR_VL_IDX, 32'h0, 1'b0);
      chk("index kept", rq, {20'h0, vid[i]});
      rw(1'b0, mvta_pkg::ADDR_VL_E0, 32'h0, 1'b0);
      chk("entry0", rq, e0[i]);
      rw(1'b0, mvta_pkg::ADDR_VL_E1, 32'h0, 1'b0);
      chk("entry1", rq, e1[i]);
      rw(1'b0, mvta_pkg::ADDR_VL_E2, 32'h0, 1'b0);
      chk("entry2", rq, e2[i]);
    end
    // Mode turned on only once the table is programmed
    vlan_mode_en <= 1'b1;
    for (int i = 0; i < 6; i++) vl_look(i, 1'b1);
    vlan_mode_en <= 1'b0;
    vl_look(1, 1'b0);
    $display("Test vlan table done");
    rw(1'b0, 12'h418, 32'h0, 1'b0);
    chk("unmapped read", {re, rq[30:0]}, 32'h80000000);
    rw(1'b1, 12'h402, 32'hffffffff, 1'b0);
    chk("unaligned write", {31'h0, re}, 32'h1);
    $display("Test unmapped access done");
    tally_and_finish();
  end
endmodule : mvta_table_access_tb

// File: hw/mvta_mc_if.sv
// Access path between the control logic and the multicast group store
interface mvta_mc_if;
  logic       wr_en;
  logic [5:0] idx;
  logic [6:0] wr_map;
  logic [6:0] rd_map;

  modport tbl (input wr_en, input idx, input wr_map, output rd_map);
  modport ctl (output wr_en, output idx, output wr_map, input rd_map);
endinterface : mvta_mc_if

// File: hw/mvta_mcast_table.sv
// Reserved multicast forwarding store, eight shared groups
module mvta_mcast_table #(
  parameter int unsigned ENTRIES = mvta_pkg::RMC_ENTRIES,
  parameter int unsigned GROUPS  = mvta_pkg::RMC_GROUPS
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Indirect access
  mvta_mc_if.tbl          acc,
  // Lookup engine
  input  wire logic       mc_req,
  input  wire logic [5:0] mc_addr_lsb,
  output logic            mc_rsp_vld,
  output logic [6:0]      mc_fwd_map
);

  logic [6:0] grp_q [GROUPS];
  logic [6:0] grp_d [GROUPS];
  logic       rsp_q;
  logic       rsp_d;
  logic [6:0] map_q;
  logic [6:0] map_d;

  // Addresses 48..63 are outside the table and hold nothing
  function automatic logic in_range(input logic [5:0] i);
    return {26'h0, i} < ENTRIES;
  endfunction : in_range

  // Sibling addresses share one group store
  function automatic logic [2:0] grp_of(input logic [5:0] i);
    return i[2:0];
  endfunction : grp_of

  always_comb begin
    grp_d = grp_q;
    if (acc.wr_en && in_range(acc.idx)) begin
      grp_d[grp_of(acc.idx)] = acc.wr_map;
    end
    acc.rd_map = in_range(acc.idx) ? grp_q[grp_of(acc.idx)] : 7'h00;
    rsp_d = mc_req;
    map_d = map_q;
    if (mc_req) begin
      // Indexed by address bits, never by group number
      map_d = in_range(mc_addr_lsb) ? grp_q[grp_of(mc_addr_lsb)] : 7'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int g = 0; g < GROUPS; g++) begin
        grp_q[g] <= mvta_pkg::RST_PORT_MAP;
      end
      rsp_q <= 1'b0;
      map_q <= mvta_pkg::RST_PORT_MAP;
    end else begin
      grp_q <= grp_d;
      rsp_q <= rsp_d;
      map_q <= map_d;
    end
  end

  assign mc_rsp_vld = rsp_q;
  assign mc_fwd_map = map_q;

endmodule : mvta_mcast_table

// File: hw/mvta_pkg.sv
// Constants and types for the multicast and VLAN table access block
package mvta_pkg;

  // Sizes
  localparam int unsigned PORTS        = 7;
  localparam int unsigned RMC_ENTRIES  = 48;
  localparam int unsigned RMC_GROUPS   = 8;
  localparam int unsigned RMC_IDX_W    = 6;
  localparam int unsigned VLAN_ENTRIES = 4096;
  localparam int unsigned VID_W        = 12;
  localparam int unsigned ADDR_W       = 12;

  // Register byte addresses
  localparam logic [11:0] ADDR_VL_E0    = 12'h400;
  localparam logic [11:0] ADDR_VL_E1    = 12'h404;
  localparam logic [11:0] ADDR_VL_E2    = 12'h408;
  localparam logic [11:0] ADDR_VL_IDX   = 12'h40c;
  localparam logic [11:0] ADDR_VL_ACC   = 12'h410;
  localparam logic [11:0] ADDR_RMC_CTRL = 12'h41c;
  localparam logic [11:0] ADDR_RMC_DATA = 12'h424;

  // Reserved multicast control fields
  localparam int unsigned CTL_IDX_LSB = 0;
  localparam int unsigned CTL_SEL_BIT = 8;
  localparam int unsigned CTL_DIR_BIT = 9;
  localparam int unsigned CTL_GO_BIT  = 10;

  // Reserved multicast data fields
  localparam int unsigned DATA_FWD_LSB = 0;
  localparam int unsigned DATA_RSV_LSB = 30;

  // VLAN access control fields
  localparam int unsigned ACC_RD_BIT    = 0;
  localparam int unsigned ACC_START_BIT = 7;

  // VLAN entry 0 fields
  localparam int unsigned E0_VALID_BIT = 31;
  localparam int unsigned E0_USEM_BIT  = 27;
  localparam int unsigned E0_PRIO_LSB  = 24;
  localparam int unsigned E0_SPAN_LSB  = 16;
  localparam int unsigned E0_FGID_LSB  = 0;

  // Reset values
  localparam logic [6:0]  RST_PORT_MAP = 7'h00;
  localparam logic [1:0]  RST_RSV      = 2'h0;
  localparam logic [11:0] RST_VID      = 12'h000;
  localparam logic [5:0]  RST_RMC_IDX  = 6'h00;

  typedef struct packed {
    logic       valid;
    logic       use_member_list;
    logic [2:0] priority_val;
    logic [2:0] spanning_instance;
    logic [6:0] filter_group_id;
    logic [6:0] egress_strip_map;
    logic [6:0] member_map;
  } mvta_vlan_entry_t;

  localparam mvta_vlan_entry_t RST_VLAN_ENTRY = '0;

endpackage : mvta_pkg

// File: hw/mvta_table_access.sv
// APB register bank for indirect multicast and VLAN table access
module mvta_table_access (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Switch mode
  input  wire logic        vlan_mode_en,
  // VLAN lookup
  input  wire logic        vl_lk_req,
  input  wire logic [11:0] vl_lk_vid,
  output logic             vl_lk_rsp_vld,
  output logic             vl_lk_hit,
  output logic             vl_lk_use_member,
  output logic [2:0]       vl_lk_priority,
  output logic [2:0]       vl_lk_spanning,
  output logic [6:0]       vl_lk_filter_group_id,
  output logic [6:0]       vl_lk_strip_map,
  output logic [6:0]       vl_lk_member_map,
  // Reserved multicast lookup
  input  wire logic        mc_lk_req,
  input  wire logic [5:0]  mc_lk_addr_lsb,
  output logic             mc_lk_rsp_vld,
  output logic [6:0]       mc_lk_fwd_map
);

  typedef enum logic [2:0] {
    st_idle,
    st_mc_op,
    st_vl_acc,
    st_vl_fin
  } mvta_state_t;

  mvta_state_t               state_q, state_d;
  logic [5:0]                rmc_idx_q, rmc_idx_d;
  logic                      rmc_sel_q, rmc_sel_d;
  logic                      rmc_dir_q, rmc_dir_d;
  logic                      rmc_go_q, rmc_go_d;
  logic [6:0]                rmc_fwd_q, rmc_fwd_d;
  logic [1:0]                rmc_rsv_q, rmc_rsv_d;
  mvta_pkg::mvta_vlan_entry_t vl_ent_q, vl_ent_d;
  logic [11:0]               vl_idx_q, vl_idx_d;
  logic                      vl_dir_q, vl_dir_d;
  logic                      vl_go_q, vl_go_d;

  mvta_pkg::mvta_vlan_entry_t vl_mem [mvta_pkg::VLAN_ENTRIES];
  mvta_pkg::mvta_vlan_entry_t vl_rd_q;
  mvta_pkg::mvta_vlan_entry_t lk_q;
  logic                      lk_vld_q, vl_mem_we;

  logic                      acc_en, wr_en, busy, mapped;
  logic [31:0]               rd_mux;

  mvta_mc_if mc ();

  mvta_mcast_table #(
    .ENTRIES (mvta_pkg::RMC_ENTRIES),
    .GROUPS  (mvta_pkg::RMC_GROUPS)
  ) u_mcast (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .acc         (mc.tbl),
    .mc_req      (mc_lk_req),
    .mc_addr_lsb (mc_lk_addr_lsb),
    .mc_rsp_vld  (mc_lk_rsp_vld),
    .mc_fwd_map  (mc_lk_fwd_map)
  );

  assign busy   = (state_q != st_idle);
  assign acc_en = psel && penable;
  assign wr_en  = acc_en && pwrite;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = acc_en && !mapped;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      mvta_pkg::ADDR_VL_E0: begin
        rd_mux[mvta_pkg::E0_VALID_BIT] = vl_ent_q.valid;
        rd_mux[mvta_pkg::E0_USEM_BIT]  = vl_ent_q.use_member_list;
        rd_mux[mvta_pkg::E0_PRIO_LSB +: 3] = vl_ent_q.priority_val;
        rd_mux[mvta_pkg::E0_SPAN_LSB +: 3] = vl_ent_q.spanning_instance;
        rd_mux[mvta_pkg::E0_FGID_LSB +: 7] = vl_ent_q.filter_group_id;
      end
      mvta_pkg::ADDR_VL_E1: rd_mux[6:0] = vl_ent_q.egress_strip_map;
      mvta_pkg::ADDR_VL_E2: rd_mux[6:0] = vl_ent_q.member_map;
      mvta_pkg::ADDR_VL_IDX: rd_mux[11:0] = vl_idx_q;
      mvta_pkg::ADDR_VL_ACC: begin
        rd_mux[mvta_pkg::ACC_RD_BIT]    = vl_dir_q;
        rd_mux[mvta_pkg::ACC_START_BIT] = vl_go_q;
      end
      mvta_pkg::ADDR_RMC_CTRL: begin
        rd_mux[mvta_pkg::CTL_IDX_LSB +: 6] = rmc_idx_q;
        rd_mux[mvta_pkg::CTL_SEL_BIT]      = rmc_sel_q;
        rd_mux[mvta_pkg::CTL_DIR_BIT]      = rmc_dir_q;
        rd_mux[mvta_pkg::CTL_GO_BIT]       = rmc_go_q;
      end
      mvta_pkg::ADDR_RMC_DATA: begin
        rd_mux[mvta_pkg::DATA_FWD_LSB +: 7] = rmc_fwd_q;
        rd_mux[mvta_pkg::DATA_RSV_LSB +: 2] = rmc_rsv_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  assign prdata = (acc_en && !pwrite) ? rd_mux : 32'h0000_0000;

  always_comb begin
    state_d   = state_q;
    rmc_idx_d = rmc_idx_q;
    rmc_sel_d = rmc_sel_q;
    rmc_dir_d = rmc_dir_q;
    rmc_go_d  = rmc_go_q;
    rmc_fwd_d = rmc_fwd_q;
    rmc_rsv_d = rmc_rsv_q;
    vl_ent_d  = vl_ent_q;
    vl_idx_d  = vl_idx_q;
    vl_dir_d  = vl_dir_q;
    vl_go_d   = vl_go_q;
    vl_mem_we = 1'b0;
    mc.wr_en  = 1'b0;
    // Writes during an operation are dropped so results cannot be torn
    if (wr_en && !busy) begin
      unique case (paddr)
        mvta_pkg::ADDR_VL_E0: begin
          vl_ent_d.valid = pwdata[mvta_pkg::E0_VALID_BIT];
          vl_ent_d.use_member_list = pwdata[mvta_pkg::E0_USEM_BIT];
          vl_ent_d.priority_val = pwdata[mvta_pkg::E0_PRIO_LSB +: 3];
          vl_ent_d.spanning_instance =
            pwdata[mvta_pkg::E0_SPAN_LSB +: 3];
          vl_ent_d.filter_group_id =
            pwdata[mvta_pkg::E0_FGID_LSB +: 7];
        end
        mvta_pkg::ADDR_VL_E1: vl_ent_d.egress_strip_map = pwdata[6:0];
        mvta_pkg::ADDR_VL_E2: vl_ent_d.member_map = pwdata[6:0];
        mvta_pkg::ADDR_VL_IDX: vl_idx_d = pwdata[11:0];
        mvta_pkg::ADDR_VL_ACC: begin
          vl_dir_d = pwdata[mvta_pkg::ACC_RD_BIT];
          vl_go_d  = pwdata[mvta_pkg::ACC_START_BIT];
          if (pwdata[mvta_pkg::ACC_START_BIT]) begin
            state_d = st_vl_acc;
          end
        end
        mvta_pkg::ADDR_RMC_CTRL: begin
          rmc_idx_d = pwdata[mvta_pkg::CTL_IDX_LSB +: 6];
          rmc_sel_d = pwdata[mvta_pkg::CTL_SEL_BIT];
          rmc_dir_d = pwdata[mvta_pkg::CTL_DIR_BIT];
          rmc_go_d  = pwdata[mvta_pkg::CTL_GO_BIT];
          if (pwdata[mvta_pkg::CTL_GO_BIT]) begin
            state_d = st_mc_op;
          end
        end
        mvta_pkg::ADDR_RMC_DATA: begin
          rmc_fwd_d = pwdata[mvta_pkg::DATA_FWD_LSB +: 7];
          rmc_rsv_d = pwdata[mvta_pkg::DATA_RSV_LSB +: 2];
        end
        default: ;
      endcase
    end
    unique case (state_q)
      st_idle: ;
      st_mc_op: begin
        // Select 0 names a table not held here: finish with no effect
        if (rmc_sel_q && !rmc_dir_q) begin
          mc.wr_en = 1'b1;
        end
        if (rmc_sel_q && rmc_dir_q) begin
          rmc_fwd_d = mc.rd_map;
        end
        rmc_go_d = 1'b0;
        state_d  = st_idle;
      end
      st_vl_acc: begin
        if (vl_dir_q) begin
          state_d = st_vl_fin;
        end else begin
          vl_mem_we = 1'b1;
          vl_go_d   = 1'b0;
          state_d   = st_idle;
        end
      end
      st_vl_fin: begin
        vl_ent_d = vl_rd_q;
        vl_go_d  = 1'b0;
        state_d  = st_idle;
      end
    endcase
  end

  assign mc.idx    = rmc_idx_q;
  assign mc.wr_map = rmc_fwd_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q   <= st_idle;
      rmc_idx_q <= mvta_pkg::RST_RMC_IDX;
      rmc_sel_q <= 1'b0;
      rmc_dir_q <= 1'b0;
      rmc_go_q  <= 1'b0;
      rmc_fwd_q <= mvta_pkg::RST_PORT_MAP;
      rmc_rsv_q <= mvta_pkg::RST_RSV;
      vl_ent_q  <= mvta_pkg::RST_VLAN_ENTRY;
      vl_idx_q  <= mvta_pkg::RST_VID;
      vl_dir_q  <= 1'b0;
      vl_go_q   <= 1'b0;
      lk_vld_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      rmc_idx_q <= rmc_idx_d;
      rmc_sel_q <= rmc_sel_d;
      rmc_dir_q <= rmc_dir_d;
      rmc_go_q  <= rmc_go_d;
      rmc_fwd_q <= rmc_fwd_d;
      rmc_rsv_q <= rmc_rsv_d;
      vl_ent_q  <= vl_ent_d;
      vl_idx_q  <= vl_idx_d;
      vl_dir_q  <= vl_dir_d;
      vl_go_q   <= vl_go_d;
      lk_vld_q  <= vl_lk_req && vlan_mode_en;
    end
  end

  // Table contents are not reset; software fills it before enabling
  always_ff @(posedge ref_clk) begin
    if (vl_mem_we) begin
      vl_mem[vl_idx_q] <= vl_ent_q;
    end
    vl_rd_q <= vl_mem[vl_idx_q];
    if (vl_lk_req) begin
      lk_q <= vl_mem[vl_lk_vid];
    end
  end

  assign vl_lk_rsp_vld         = lk_vld_q;
  assign vl_lk_hit             = lk_vld_q && lk_q.valid;
  assign vl_lk_use_member      = lk_vld_q && lk_q.use_member_list;
  assign vl_lk_priority        = lk_q.priority_val;
  assign vl_lk_spanning        = lk_q.spanning_instance;
  assign vl_lk_filter_group_id = lk_q.filter_group_id;
  assign vl_lk_strip_map       = lk_q.egress_strip_map;
  assign vl_lk_member_map      = lk_q.member_map;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_mc_wr_done;
    wr_en && !busy && paddr == mvta_pkg::ADDR_RMC_CTRL &&
      pwdata[mvta_pkg::CTL_GO_BIT] && !pwdata[mvta_pkg::CTL_DIR_BIT]
      |=> rmc_go_q && mc.wr_en == $past(pwdata[mvta_pkg::CTL_SEL_BIT])
        ##1 !rmc_go_q;
  endproperty
  a_mc_wr_done: assert property (p_mc_wr_done)
    else $error("multicast write did not finish in one cycle");

  property p_mc_rd_load;
    state_q == st_mc_op && rmc_sel_q && rmc_dir_q
      |=> rmc_fwd_q == $past(mc.rd_map) && !rmc_go_q;
  endproperty
  a_mc_rd_load: assert property (p_mc_rd_load)
    else $error("multicast read result not loaded");

  property p_vl_wr_done;
    wr_en && !busy && paddr == mvta_pkg::ADDR_VL_ACC &&
      pwdata[mvta_pkg::ACC_START_BIT] && !pwdata[mvta_pkg::ACC_RD_BIT]
      |=> vl_go_q ##1 !vl_go_q && state_q == st_idle;
  endproperty
  a_vl_wr_done: assert property (p_vl_wr_done)
    else $error("VLAN write start did not clear after one cycle");

  property p_vl_rd_done;
    wr_en && !busy && paddr == mvta_pkg::ADDR_VL_ACC &&
      pwdata[mvta_pkg::ACC_START_BIT] && pwdata[mvta_pkg::ACC_RD_BIT]
      |=> vl_go_q [*2] ##1 !vl_go_q;
  endproperty
  a_vl_rd_done: assert property (p_vl_rd_done)
    else $error("VLAN read start did not clear after two cycles");

  property p_busy_ignore;
    wr_en && busy |=> $stable(vl_idx_q) && $stable(rmc_idx_q) &&
      $stable(vl_dir_q) && $stable(rmc_dir_q);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("register changed by a write while busy");

  property p_go_reads_one;
    acc_en && !pwrite && paddr == mvta_pkg::ADDR_VL_ACC && busy &&
      state_q != st_mc_op |-> prdata[mvta_pkg::ACC_START_BIT];
  endproperty
  a_go_reads_one: assert property (p_go_reads_one)
    else $error("start flag read zero during VLAN operation");

  property p_mode_gate;
    vl_lk_req |=> vl_lk_rsp_vld == $past(vlan_mode_en);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("VLAN lookup answer does not follow mode enable");

  property p_hit_valid;
    vl_lk_req && vlan_mode_en |=> vl_lk_hit == $past(vl_mem[vl_lk_vid].valid);
  endproperty
  a_hit_valid: assert property (p_hit_valid)
    else $error("VLAN hit disagrees with entry valid flag");

  property p_unmapped_err;
    acc_en && paddr[1:0] != 2'h0 |-> pslverr && pready;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unaligned access not flagged as error");

endmodule : mvta_table_access
